/* File: smp_idle_timer.sv */
// line idle timer that flags a gap of the programmed length
`default_nettype none

module smp_idle_timer #(
   parameter int P_CYC_PER_MS = 100000
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_byte,
   input  wire logic [15:0] i_interval_ms,
   output logic             o_gap
);

   logic [16:0] cyc_r,  cyc_nxt;
   logic [15:0] ms_r,   ms_nxt;
   logic        done_r, done_nxt;
   logic        gap_r,  gap_nxt;

   // a zero interval disables gap detection; one flag per idle period
   always_comb begin
      cyc_nxt  = cyc_r;
      ms_nxt   = ms_r;
      done_nxt = done_r;
      gap_nxt  = 1'b0;
      if (i_byte) begin
         cyc_nxt  = 17'h00000;
         ms_nxt   = 16'h0000;
         done_nxt = 1'b0;
      end else if (!done_r && i_interval_ms != 16'h0000) begin
         if (cyc_r == 17'(P_CYC_PER_MS - 1)) begin
            cyc_nxt = 17'h00000;
            ms_nxt  = ms_r + 16'h0001;
            if (ms_r + 16'h0001 >= i_interval_ms) begin
               gap_nxt  = 1'b1;
               done_nxt = 1'b1;
            end
         end else begin
            cyc_nxt = cyc_r + 17'h00001;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         cyc_r  <= 17'h00000;
         ms_r   <= 16'h0000;
         done_r <= 1'b0;
         gap_r  <= 1'b0;
      end else begin
         cyc_r  <= cyc_nxt;
         ms_r   <= ms_nxt;
         done_r <= done_nxt;
         gap_r  <= gap_nxt;
      end
   end

   assign o_gap = gap_r;

endmodule

`default_nettype wire

/* File: smp_parser.sv */
// serial message parser: slot capture, idle-gap framing and snarfer pass-through
// Notes on behaviour
// - instances with the same start and stop sequence land in one slot, any length.
// - shorter instances leave later stored words in place; stale byte may follow the stop byte.
// - snarfer mode passes every received byte onward, bypassing the slot parser.
// - with no start sequence, an idle gap of the sync interval delimits messages.
// - idle-gap framing is selectable even when a start value exists in payload.
// - sync interval is programmed per channel in milliseconds, e.g. twelve.
// - a wildcard covers exactly one whole start byte; other bytes match exactly.
// - wildcards are given per byte as a mask beside the hex start sequence.
// - 16-bit words; even position holds bytes 2k,2k+1, odd position swapped.
// - outside idle-gap framing only the start sequence selects the slot; length or stop only ends parsing.
`default_nettype none

module smp_parser #(
   parameter int P_CYC_PER_MS = smp_pkg::CYC_PER_MS
) (
   input  wire logic                            i_ref_clk,
   input  wire logic                            i_reset,
   input  wire logic [smp_pkg::ADDR_W-1:0]      i_addr,
   input  wire logic [31:0]                     i_wr_data,
   input  wire logic                            i_wr_en,
   input  wire logic                            i_rd_en,
   output logic      [31:0]                     o_rd_data,
   input  wire logic [7:0]                      i_rx_data,
   input  wire logic                            i_rx_valid,
   output logic      [7:0]                      o_snarf_data,
   output logic                                 o_snarf_valid,
   output logic                                 o_msg_done,
   output logic      [smp_pkg::SLOT_W-1:0]      o_msg_slot
);

   localparam int MEM_N = smp_pkg::SLOTS * smp_pkg::MAX_BYTES;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [3:0]                  ctrl_r,     ctrl_nxt;
   logic [15:0]                 sync_ms_r,  sync_ms_nxt;
   logic [31:0]                 seq_r       [smp_pkg::SLOTS];
   logic [31:0]                 seq_nxt     [smp_pkg::SLOTS];
   logic [31:0]                 cfg_r       [smp_pkg::SLOTS];
   logic [31:0]                 cfg_nxt     [smp_pkg::SLOTS];
   logic [7:0]                  mem_r       [MEM_N];
   logic [7:0]                  mem_nxt     [MEM_N];
   logic [23:0]                 hist_r,     hist_nxt;
   smp_pkg::smp_state_e         state_r,    state_nxt;
   logic [smp_pkg::SLOT_W-1:0]  slot_r,     slot_nxt;
   logic [4:0]                  idx_r,      idx_nxt;
   logic                        gap_seen_r, gap_seen_nxt;
   logic [15:0]                 count_r,    count_nxt;
   logic [7:0]                  snarf_r,    snarf_nxt;
   logic                        snarf_v_r,  snarf_v_nxt;
   logic                        done_r,     done_nxt;
   logic [smp_pkg::SLOT_W-1:0]  dslot_r,    dslot_nxt;
   logic [31:0]                 rd_r,       rd_nxt;

   logic                        gap;
   logic [31:0]                 cand;
   logic [smp_pkg::SLOTS*32-1:0] seq_flat;
   logic [smp_pkg::SLOTS*3-1:0] len_flat;
   logic [smp_pkg::SLOTS*4-1:0] wild_flat;
   logic                        hit;
   logic [smp_pkg::SLOT_W-1:0]  hit_slot;
   logic [2:0]                  hit_len;
   logic [smp_pkg::SLOT_W-1:0]  sync_slot;

   assign cand = {hist_r, i_rx_data};

   for (genvar s = 0; s < smp_pkg::SLOTS; s++) begin : g_flat
      assign seq_flat[s*32 +: 32] = seq_r[s];
      assign len_flat[s*3 +: 3]   = cfg_r[s][smp_pkg::CFG_LEN_LSB +: 3];
      assign wild_flat[s*4 +: 4]  = cfg_r[s][smp_pkg::CFG_WILD_LSB +: 4];
   end

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   smp_idle_timer #(
      .P_CYC_PER_MS (P_CYC_PER_MS)
   ) u_idle (
      .i_ref_clk     (i_ref_clk),
      .i_reset       (i_reset),
      .i_byte        (i_rx_valid),
      .i_interval_ms (sync_ms_r),
      .o_gap         (gap)
   );

   smp_start_match u_match (
      .i_cand (cand),
      .i_seq  (seq_flat),
      .i_len  (len_flat),
      .i_wild (wild_flat),
      .o_hit  (hit),
      .o_slot (hit_slot),
      .o_len  (hit_len)
   );

   // idle-gap messages go to the lowest slot without a start sequence
   always_comb begin
      sync_slot = '0;
      for (int s = smp_pkg::SLOTS - 1; s >= 0; s--) begin
         if (cfg_r[s][smp_pkg::CFG_LEN_LSB +: 3] == 3'd0) begin
            sync_slot = smp_pkg::SLOT_W'(s);
         end
      end
   end

   // -------------------------------------------------------------
   // parser
   // -------------------------------------------------------------
   always_comb begin
      logic [4:0] cnt;
      logic [7:0] stop;
      logic       end_now;
      logic       reopen;
      logic [5:0] base;
      cnt          = cfg_r[slot_r][smp_pkg::CFG_COUNT_LSB +: 5];
      stop         = cfg_r[slot_r][smp_pkg::CFG_STOP_LSB +: 8];
      end_now      = 1'b0;
      reopen       = 1'b0;
      base         = 6'h00;
      mem_nxt      = mem_r;
      hist_nxt     = hist_r;
      state_nxt    = state_r;
      slot_nxt     = slot_r;
      idx_nxt      = idx_r;
      gap_seen_nxt = gap_seen_r | gap;
      count_nxt    = count_r;
      snarf_nxt    = snarf_r;
      snarf_v_nxt  = 1'b0;
      done_nxt     = 1'b0;
      dslot_nxt    = dslot_r;
      if (cnt == 5'd0) begin
         cnt = 5'(smp_pkg::MAX_BYTES);
      end
      if (!ctrl_r[smp_pkg::CTRL_EN_BIT]) begin
         state_nxt = smp_pkg::SMP_HUNT;
      end else if (ctrl_r[smp_pkg::CTRL_SNARF_BIT]) begin
         // every byte is forwarded; slot parsing is held off
         state_nxt = smp_pkg::SMP_HUNT;
         if (i_rx_valid) begin
            snarf_nxt   = i_rx_data;
            snarf_v_nxt = 1'b1;
         end
      end else begin
         case (state_r)
            smp_pkg::SMP_HUNT: begin
               if (i_rx_valid) begin
                  hist_nxt = cand[23:0];
                  if (ctrl_r[smp_pkg::CTRL_SYNC_BIT]) begin
                     // first byte after an idle gap opens the message
                     if (gap_seen_r || gap) begin
                        gap_seen_nxt = 1'b0;
                        slot_nxt     = sync_slot;
                        base         = {sync_slot, 4'h0};
                        mem_nxt[base] = i_rx_data;
                        idx_nxt      = 5'd1;
                        state_nxt    = smp_pkg::SMP_COLLECT;
                     end
                  end else if (hit) begin
                     slot_nxt = hit_slot;
                     base     = {hit_slot, 4'h0};
                     for (int i = 0; i < smp_pkg::SEQ_BYTES; i++) begin
                        if (3'(i) < hit_len) begin
                           mem_nxt[base + 6'(i)] = cand[8*(int'(hit_len) - 1 - i) +: 8];
                        end
                     end
                     idx_nxt   = {2'b00, hit_len};
                     state_nxt = smp_pkg::SMP_COLLECT;
                  end
               end
            end
            smp_pkg::SMP_COLLECT: begin
               if (ctrl_r[smp_pkg::CTRL_SYNC_BIT] && gap) begin
                  // idle gap closes the instance; the next byte opens another
                  end_now = 1'b1;
                  reopen  = i_rx_valid;
               end else if (i_rx_valid) begin
                  hist_nxt = cand[23:0];
                  base     = {slot_r, 4'h0};
                  // old bytes beyond a short instance are left in place
                  if (idx_r < 5'(smp_pkg::MAX_BYTES)) begin
                     mem_nxt[base + 6'(idx_r)] = i_rx_data;
                  end
                  // keep counting past the store limit so a long length end still fires
                  if (idx_r != 5'h1F) begin
                     idx_nxt = idx_r + 5'd1;
                  end
                  if (ctrl_r[smp_pkg::CTRL_LEN_END_BIT]) begin
                     end_now = (idx_r + 5'd1 >= cnt);
                  end else if (!ctrl_r[smp_pkg::CTRL_SYNC_BIT]) begin
                     end_now = (i_rx_data == stop);
                  end
               end
               if (end_now) begin
                  state_nxt = smp_pkg::SMP_HUNT;
                  done_nxt  = 1'b1;
                  dslot_nxt = slot_r;
                  count_nxt = count_r + 16'h0001;
               end
               // a byte on the gap pulse is already the first of the next instance
               if (reopen) begin
                  hist_nxt      = cand[23:0];
                  gap_seen_nxt  = 1'b0;
                  slot_nxt      = sync_slot;
                  base          = {sync_slot, 4'h0};
                  mem_nxt[base] = i_rx_data;
                  idx_nxt       = 5'd1;
                  state_nxt     = smp_pkg::SMP_COLLECT;
               end
            end
            default: begin
               state_nxt = smp_pkg::SMP_HUNT;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // register port
   // -------------------------------------------------------------
   always_comb begin
      logic [11:0] rel;
      logic [5:0]  pair;
      rel         = i_addr - smp_pkg::REG_SLOT_BASE;
      pair        = {i_addr[7:6], i_addr[5:3], 1'b0};
      ctrl_nxt    = ctrl_r;
      sync_ms_nxt = sync_ms_r;
      seq_nxt     = seq_r;
      cfg_nxt     = cfg_r;
      rd_nxt      = 32'h0000_0000;
      if (i_wr_en) begin
         if (i_addr == smp_pkg::REG_CTRL) begin
            ctrl_nxt = i_wr_data[3:0];
         end else if (i_addr == smp_pkg::REG_SYNC) begin
            sync_ms_nxt = i_wr_data[15:0];
         end else if (i_addr >= smp_pkg::REG_SLOT_BASE && i_addr < smp_pkg::REG_SLOT_END &&
                      i_addr[1:0] == 2'b00) begin
            if (rel[2]) begin
               cfg_nxt[rel[4:3]] = i_wr_data & smp_pkg::CFG_MASK;
            end else begin
               seq_nxt[rel[4:3]] = i_wr_data;
            end
         end
      end
      if (i_rd_en) begin
         if (i_addr == smp_pkg::REG_CTRL) begin
            rd_nxt = {28'h0000000, ctrl_r};
         end else if (i_addr == smp_pkg::REG_SYNC) begin
            rd_nxt = {16'h0000, sync_ms_r};
         end else if (i_addr == smp_pkg::REG_STATUS) begin
            rd_nxt = {19'h00000, idx_r, 2'h0, gap_seen_r,
                      (state_r == smp_pkg::SMP_COLLECT), slot_r, dslot_r};
         end else if (i_addr == smp_pkg::REG_COUNT) begin
            rd_nxt = {16'h0000, count_r};
         end else if (i_addr >= smp_pkg::REG_SLOT_BASE && i_addr < smp_pkg::REG_SLOT_END &&
                      i_addr[1:0] == 2'b00) begin
            rd_nxt = rel[2] ? cfg_r[rel[4:3]] : seq_r[rel[4:3]];
         end else if (i_addr[11:8] == smp_pkg::REG_DATA_PAGE && i_addr[1:0] == 2'b00) begin
            // even position: first byte high; odd position: same pair swapped
            if (i_addr[2]) begin
               rd_nxt = {16'h0000, mem_r[pair + 6'd1], mem_r[pair]};
            end else begin
               rd_nxt = {16'h0000, mem_r[pair], mem_r[pair + 6'd1]};
            end
         end
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_r     <= smp_pkg::CTRL_RESET;
         sync_ms_r  <= smp_pkg::SYNC_RESET;
         for (int s = 0; s < smp_pkg::SLOTS; s++) begin
            seq_r[s] <= smp_pkg::SEQ_RESET;
            cfg_r[s] <= smp_pkg::CFG_RESET;
         end
         for (int m = 0; m < MEM_N; m++) begin
            mem_r[m] <= 8'h00;
         end
         hist_r     <= 24'h000000;
         state_r    <= smp_pkg::SMP_HUNT;
         slot_r     <= '0;
         idx_r      <= 5'd0;
         gap_seen_r <= 1'b0;
         count_r    <= 16'h0000;
         snarf_r    <= 8'h00;
         snarf_v_r  <= 1'b0;
         done_r     <= 1'b0;
         dslot_r    <= '0;
         rd_r       <= 32'h0000_0000;
      end else begin
         ctrl_r     <= ctrl_nxt;
         sync_ms_r  <= sync_ms_nxt;
         seq_r      <= seq_nxt;
         cfg_r      <= cfg_nxt;
         mem_r      <= mem_nxt;
         hist_r     <= hist_nxt;
         state_r    <= state_nxt;
         slot_r     <= slot_nxt;
         idx_r      <= idx_nxt;
         gap_seen_r <= gap_seen_nxt;
         count_r    <= count_nxt;
         snarf_r    <= snarf_nxt;
         snarf_v_r  <= snarf_v_nxt;
         done_r     <= done_nxt;
         dslot_r    <= dslot_nxt;
         rd_r       <= rd_nxt;
      end
   end

   assign o_rd_data     = rd_r;
   assign o_snarf_data  = snarf_r;
   assign o_snarf_valid = snarf_v_r;
   assign o_msg_done    = done_r;
   assign o_msg_slot    = dslot_r;

endmodule

`default_nettype wire

/* File: smp_parser_properties.sv */
// port-level checker for the serial message parser
`default_nettype none

module smp_parser_properties #(
   parameter int P_CYC_PER_MS = 10
) (
   input wire logic                         i_ref_clk,
   input wire logic                         i_reset,
   input wire logic [smp_pkg::ADDR_W-1:0]   i_addr,
   input wire logic                         i_rd_en,
   input wire logic [31:0]                  o_rd_data,
   input wire logic [7:0]                   i_rx_data,
   input wire logic                         i_rx_valid,
   input wire logic [7:0]                   o_snarf_data,
   input wire logic                         o_snarf_valid,
   input wire logic                         o_msg_done,
   input wire logic [smp_pkg::SLOT_W-1:0]   o_msg_slot
);
   // ----------------------------------------
   // line idle counter
   // ----------------------------------------
   // wide enough that it never wraps within a run
   logic [31:0] idle_r;
   logic [31:0] idle_nxt;
   always_comb idle_nxt = i_rx_valid ? 32'h0 : idle_r + 32'h1;
   always_ff @(posedge i_ref_clk or posedge i_reset)
      if (i_reset) idle_r <= 32'h0;
      else idle_r <= idle_nxt;

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   AST_RD_IDLE: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
      else $error("read data not zero outside answer cycle");
   AST_UNMAPPED: assert property (i_rd_en && (i_addr[1:0] != 2'h0 || i_addr >= 12'h200
      || (i_addr >= 12'h030 && i_addr < 12'h100)) |=> o_rd_data == 32'h0)
      else $error("unmapped read returned data");
   AST_WORD16: assert property (i_rd_en && i_addr[11:8] == 4'h1 |=> o_rd_data[31:16] == 16'h0)
      else $error("stored word wider than 16 bits");
   AST_SNARF_DATA: assert property (o_snarf_valid |-> $past(i_rx_valid) && o_snarf_data == $past(i_rx_data))
      else $error("forwarded byte not the byte received one cycle before");
   AST_SNARF_HOLD: assert property (!o_snarf_valid |-> $stable(o_snarf_data))
      else $error("forwarded byte changed without strobe");
   AST_SLOT_HOLD: assert property (!o_msg_done |-> $stable(o_msg_slot))
      else $error("slot changed without a finished message");
   AST_GAP_DONE: assert property (o_msg_done && !$past(i_rx_valid) |-> idle_r >= P_CYC_PER_MS)
      else $error("message closed without byte or idle gap");
   AST_RESET_ZERO: assert property ($past(i_reset) |-> !o_msg_done && !o_snarf_valid && o_rd_data == 32'h0)
      else $error("output active at first edge after reset");
endmodule

bind smp_parser smp_parser_properties #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_props (
   .i_ref_clk, .i_reset, .i_addr, .i_rd_en, .o_rd_data, .i_rx_data, .i_rx_valid,
   .o_snarf_data, .o_snarf_valid, .o_msg_done, .o_msg_slot
);

`default_nettype wire

/* File: smp_parser_tb.sv */
// self-checking bench for the serial message parser
`default_nettype none

module smp_parser_tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam int P = 10;
   logic                        i_ref_clk = 1'b0;
   logic                        i_reset   = 1'b1;
   logic [smp_pkg::ADDR_W-1:0]  i_addr    = 12'h000;
   logic [31:0]                 i_wr_data = 32'h0;
   logic                        i_wr_en   = 1'b0;
   logic                        i_rd_en   = 1'b0;
   logic [31:0]                 o_rd_data;
   logic [7:0]                  i_rx_data;
   logic                        i_rx_valid;
   logic [7:0]                  o_snarf_data;
   logic                        o_snarf_valid;
   logic                        o_msg_done;
   logic [smp_pkg::SLOT_W-1:0]  o_msg_slot;
   int                          mismatches  = 0;
   int                          check_count = 0;
   int                          done_n      = 0;
   logic [7:0]                  snq[$];
   logic [7:0]                  exp_q[$];

   always #5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) if (o_snarf_valid === 1'b1) snq.push_back(o_snarf_data);
   always @(posedge i_ref_clk) if (o_msg_done === 1'b1) done_n++;

   smp_parser #(.P_CYC_PER_MS(P)) uut (
      .i_ref_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data,
      .i_rx_data, .i_rx_valid, .o_snarf_data, .o_snarf_valid, .o_msg_done, .o_msg_slot
   );
   smp_serial_tx tx (.i_ref_clk(i_ref_clk), .o_data(i_rx_data), .o_valid(i_rx_valid));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_en   <= 1'b1;
      @(posedge i_ref_clk);
      i_wr_en   <= 1'b0;
      // one idle edge so a following write never re-drives the strobe in this step
      @(posedge i_ref_clk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      i_addr  <= a;
      i_rd_en <= 1'b1;
      @(posedge i_ref_clk);
      i_rd_en <= 1'b0;
      @(posedge i_ref_clk);
      chk(o_rd_data, e);
   endtask
   function automatic logic [11:0] wa(input int s, input int p);
      return 12'h100 + 12'(s * 64 + p * 4);
   endfunction
   task automatic msg(input logic [7:0] m[$], input int sp);
      foreach (m[i]) tx.send(m[i], (i == m.size() - 1) ? 1 : sp);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #300000;
      mismatches++;
      test_done;
   end

   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      @(posedge i_ref_clk);
      rc(12'h000, 32'h0);
      rc(12'h004, 32'h0000_000C);
      rc(12'h00C, 32'h0);
      rc(12'h014, 32'h0);
      rc(12'h040, 32'h0);
      rc(12'h006, 32'h0);
      wr(12'h014, 32'hFFFF_FFFF);
      rc(12'h014, 32'h001F_FFF7);
      $display("test reset values done");
      // slot 0: start AA BB, stop byte 46
      wr(12'h010, 32'h0000_BBAA);
      wr(12'h014, 32'h0000_4602);
      wr(12'h000, 32'h0000_0001);
      msg({8'hAA, 8'hBB, 8'h11, 8'h22, 8'h33, 8'h46}, 0);
      chk(32'(o_msg_done), 32'h1);
      rc(wa(0, 0), 32'h0000_AABB);
      rc(wa(0, 1), 32'h0000_BBAA);
      rc(wa(0, 4), 32'h0000_3346);
      msg({8'hAA, 8'hBB, 8'h44, 8'h46}, 2);
      rc(wa(0, 2), 32'h0000_4446);
      rc(wa(0, 4), 32'h0000_3346);
      rc(12'h00C, 32'h2);
      $display("test stop end done");
      // slot 1: start AA ** BB with the middle byte wildcarded
      wr(12'h018, 32'h00BB_00AA);
      wr(12'h01C, 32'h0000_4623);
      msg({8'hAA, 8'h77, 8'hBB, 8'h55, 8'h46}, 0);
      @(posedge i_ref_clk);
      chk(32'(o_msg_slot), 32'h1);
      rc(wa(1, 0), 32'h0000_AA77);
      msg({8'hAA, 8'h77, 8'hCC, 8'h46}, 0);
      rc(12'h00C, 32'h3);
      // slot 2: start 5A, end by a count of 3
      wr(12'h020, 32'h0000_005A);
      wr(12'h024, 32'h0003_0001);
      wr(12'h000, 32'h0000_0005);
      msg({8'h5A, 8'h01, 8'h02, 8'h03}, 0);
      @(posedge i_ref_clk);
      chk(32'(o_msg_slot), 32'h2);
      rc(wa(2, 0), 32'h0000_5A01);
      rc(wa(2, 2), 32'h0000_0200);
      rc(12'h00C, 32'h4);
      $display("test start match done");
      wr(12'h000, 32'h0000_0003);
      snq.delete();
      exp_q = {8'h12, 8'h46, 8'hAA, 8'hBB};
      msg(exp_q, 0);
      @(posedge i_ref_clk);
      chk(32'(snq.size()), 32'h4);
      foreach (exp_q[i]) chk(32'(snq[i]), 32'(exp_q[i]));
      rc(12'h00C, 32'h4);
      $display("test snarfer done");
      // idle framing: 3 ms at 10 cycles a unit, bytes 21 cycles apart
      wr(12'h004, 32'h0000_0003);
      wr(12'h000, 32'h0000_0009);
      repeat (40) @(posedge i_ref_clk);
      msg({8'hAA, 8'hBB, 8'h46, 8'hC1}, 20);
      rc(12'h00C, 32'h4);
      repeat (40) @(posedge i_ref_clk);
      chk(32'(o_msg_slot), 32'h3);
      rc(12'h00C, 32'h5);
      rc(wa(3, 0), 32'h0000_AABB);
      rc(wa(3, 2), 32'h0000_46C1);
      chk(32'(done_n), 32'h5);
      $display("test idle gap done");
      test_done;
   end
endmodule

`default_nettype wire

/* File: smp_pkg.sv */
// shared constants and types for the serial message parser
`default_nettype none

package smp_pkg;

   // -------------------------------------------------------------
   // structure
   // -------------------------------------------------------------
   localparam int SLOTS     = 4;
   localparam int SLOT_W    = 2;
   localparam int MAX_BYTES = 16;
   localparam int POS_W     = 4;
   localparam int SEQ_BYTES = 4;
   localparam int ADDR_W    = 12;

   // -------------------------------------------------------------
   // register offsets (byte addresses, one 32-bit word each)
   // -------------------------------------------------------------
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_SYNC      = 12'h004;
   localparam logic [11:0] REG_STATUS    = 12'h008;
   localparam logic [11:0] REG_COUNT     = 12'h00C;
   localparam logic [11:0] REG_SLOT_BASE = 12'h010;
   localparam logic [11:0] REG_SLOT_END  = 12'h030;
   localparam logic [3:0]  REG_DATA_PAGE = 4'h1;

   // -------------------------------------------------------------
   // fields and reset values
   // -------------------------------------------------------------
   localparam int CTRL_EN_BIT      = 0;
   localparam int CTRL_SNARF_BIT   = 1;
   localparam int CTRL_LEN_END_BIT = 2;
   localparam int CTRL_SYNC_BIT    = 3;
   localparam logic [3:0]  CTRL_RESET = 4'h0;
   localparam logic [15:0] SYNC_RESET = 16'h000C;
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
   localparam logic [31:0] SEQ_RESET  = 32'h0000_0000;
   localparam int CFG_LEN_LSB   = 0;
   localparam int CFG_WILD_LSB  = 4;
   localparam int CFG_STOP_LSB  = 8;
   localparam int CFG_COUNT_LSB = 16;
   localparam logic [31:0] CFG_MASK = 32'h001F_FFF7;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYNC_UNIT_NS  = 1000000;
   localparam int CYC_PER_MS    = SYNC_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic {SMP_HUNT, SMP_COLLECT} smp_state_e;

endpackage

`default_nettype wire

/* File: smp_serial_tx.sv */
// serial line stand-in that hands received bytes over as one-cycle strobes
`default_nettype none

module smp_serial_tx (
   input  wire logic       i_ref_clk,
   output var  logic [7:0] o_data,
   output var  logic       o_valid
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      o_data  = 8'h00;
      o_valid = 1'b0;
   end

   // caller sits just after a rising edge; gap counts idle edges after the byte
   task automatic send(input logic [7:0] b, input int gap);
      o_data  <= b;
      o_valid <= 1'b1;
      @(posedge i_ref_clk);
      if (gap > 0) begin
         o_valid <= 1'b0;
         // idle line must not look like the stale byte
         o_data  <= ~b;
         repeat (gap) @(posedge i_ref_clk);
      end
   endtask
endmodule

`default_nettype wire

/* File: smp_start_match.sv */
// start sequence matcher over the most recent received bytes
`default_nettype none

module smp_start_match (
   input  wire logic [31:0]                        i_cand,
   input  wire logic [smp_pkg::SLOTS*32-1:0]       i_seq,
   input  wire logic [smp_pkg::SLOTS*3-1:0]        i_len,
   input  wire logic [smp_pkg::SLOTS*4-1:0]        i_wild,
   output logic                                    o_hit,
   output logic [smp_pkg::SLOT_W-1:0]              o_slot,
   output logic [2:0]                              o_len
);

   logic [smp_pkg::SLOTS-1:0] hit;

   // i_cand holds the newest byte in bits 7:0; sequence byte 0 is sent first
   for (genvar s = 0; s < smp_pkg::SLOTS; s++) begin : g_slot
      always_comb begin
         logic [2:0] len;
         logic       ok;
         len = i_len[s*3 +: 3];
         ok  = (len != 3'd0) && (len <= 3'(smp_pkg::SEQ_BYTES));
         for (int i = 0; i < smp_pkg::SEQ_BYTES; i++) begin
            if (3'(i) < len) begin
               // a wildcard stands for one whole byte and matches anything
               if (!i_wild[s*4 + i] &&
                   i_seq[s*32 + 8*i +: 8] != i_cand[8*(int'(len) - 1 - i) +: 8]) begin
                  ok = 1'b0;
               end
            end
         end
         hit[s] = ok;
      end
   end

   // lowest slot wins when two sequences overlap
   always_comb begin
      o_hit  = 1'b0;
      o_slot = '0;
      o_len  = 3'd0;
      for (int s = smp_pkg::SLOTS - 1; s >= 0; s--) begin
         if (hit[s]) begin
            o_hit  = 1'b1;
            o_slot = smp_pkg::SLOT_W'(s);
            o_len  = i_len[s*3 +: 3];
         end
      end
   end

endmodule

`default_nettype wire
